// ==== logic/timer_pkg.sv ====
// Package with register map, field layout and state types of the delay-counter channel
package timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_UNIT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_PRESCALE   = 8'h04;
  localparam logic [7:0] OFS_MODE       = 8'h08;
  localparam logic [7:0] OFS_RELOAD     = 8'h0C;
  localparam logic [7:0] OFS_COUNT      = 8'h10;
  localparam logic [7:0] OFS_START      = 8'h14;
  localparam logic [7:0] OFS_STOP       = 8'h18;
  localparam logic [7:0] OFS_ENABLE     = 8'h1C;
  localparam logic [7:0] OFS_CH_STATUS  = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MODE_CSEL_LSB  = 0;
  localparam int unsigned MODE_EIGHT_BIT = 2;
  localparam int unsigned MODE_EDGE_LSB  = 3;
  localparam int unsigned MODE_FILTER    = 5;
  localparam int unsigned MODE_OUT_MODE  = 6;
  localparam int unsigned MODE_OUT_EN    = 7;
  localparam int unsigned TRIG_LOWER     = 0;
  localparam int unsigned TRIG_UPPER     = 1;
  localparam int unsigned IRQ_DONE       = 0;

  // ----------------------------------------------------------------
  // Widths, reset values and counts
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PRESC_SEL_W    = 4;
  localparam int unsigned FILTER_SAMPLES = 2;
  localparam logic [15:0] RELOAD_RST     = 16'h0000;
  localparam logic [15:0] PRESCALE_RST   = 16'h0000;
  localparam logic [7:0]  MODE_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Valid edge encodings and channel states
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_LOAD  = 2'b10,
    ST_COUNT = 2'b11
  } chan_state_type;

endpackage

// ==== logic/event_if.sv ====
// Interface between the channel core and its input conditioner
`timescale 1ns/1ns
interface event_if;
  logic       edge_pulse;
  logic       filter_en;
  logic [1:0] edge_sel;

  // Conditioner side
  modport cond (input filter_en, input edge_sel, output edge_pulse);
  // Channel side
  modport chan (output filter_en, output edge_sel, input edge_pulse);
endinterface

// ==== logic/input_conditioner.sv ====
// Synchroniser, optional noise filter and edge detector for the timer event input
`timescale 1ns/1ns
module input_conditioner
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Control
  input  wire logic clear_i,
  // Pin
  input  wire logic timer_event_input_i,
  // Channel side
  event_if.cond     ev
);

  logic                      sync1_reg;
  logic                      sync2_reg;
  logic [FILTER_SAMPLES-1:0] hist_reg;
  logic                      level_reg;
  logic                      level_next;
  logic                      edge_reg;
  logic                      stable;
  logic                      rise;
  logic                      fall;

  // Two-stage synchroniser ahead of all other logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= timer_event_input_i; // RULE_16
      sync2_reg <= sync1_reg;
    end
  end

  // Sample history for the filter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= {hist_reg[FILTER_SAMPLES-2:0], sync2_reg};
    end
  end

  // Filter passes a level only after it held for all samples
  always_comb begin
    stable     = (&hist_reg & sync2_reg) | (~(|hist_reg) & ~sync2_reg);
    level_next = ev.filter_en ? (stable ? sync2_reg : level_reg) : sync2_reg; // RULE_15
    rise       = level_next & ~level_reg;
    fall       = ~level_next & level_reg;
  end

  // Level tracks even while cleared so power-up makes no false edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_reg <= 1'b0;
      edge_reg  <= 1'b0;
    end else begin
      level_reg <= level_next;
      if (clear_i) begin
        edge_reg <= 1'b0;
      end else if (ev.edge_sel == EDGE_FALL) begin
        edge_reg <= fall;
      end else if (ev.edge_sel == EDGE_RISE) begin
        edge_reg <= rise;
      end else begin
        edge_reg <= rise | fall;
      end
    end
  end

  assign ev.edge_pulse = edge_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_filter_bypass: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!ev.filter_en && sync2_reg != level_reg) |=> level_reg == $past(sync2_reg)) // RULE_15
    else $error("unfiltered level did not follow input");

  a_filter_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ev.filter_en && !stable) |=> level_reg == $past(level_reg)) // RULE_15
    else $error("filter passed an unstable level");

endmodule

// ==== logic/timer_delay_counter.sv ====
// Delay-counter timer channel with APB registers, prescaler and interrupt
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns

// Overview of operation
// (RULE_01) The interrupt repeats every count clock period times reload value plus one.
// (RULE_02) A start write, lower or upper half, sets its enable bit and waits for an input edge.
// (RULE_03) A valid input edge loads the reload value, then the counter steps down once per count clock.
// (RULE_04) On reaching zero the channel raises its interrupt and halts until the next trigger.
// (RULE_05) While enabled, a further start write acts as a trigger and begins a countdown.
// (RULE_06) The reload value may be written any time and is used only at the next load.
// (RULE_07) The start bit is a one-shot trigger that always reads back as zero.
// (RULE_08) A stop write clears the enable bit and halts counting with the count held.
// (RULE_09) The count is readable at any time and the channel status register reads zero.
// (RULE_10) While the unit is powered down, writes to all other registers are ignored and its clock stops.
// (RULE_11) Powering the unit down returns all channel state and registers to reset values.
// (RULE_12) Only in 8-bit mode of a split channel may all four prescaled clocks be chosen.
// (RULE_13) Software keeps the output mode bit at zero for this function.
// (RULE_14) Software keeps the output pin enable at zero so the output stays idle.
// (RULE_15) The filter enable bit turns the input noise filter on or off.
// (RULE_16) The event input is synchronised before edge detection.
module timer_delay_counter
  import timer_pkg::*;
#(
  parameter bit SPLIT_CAPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Event pin
  input  wire logic        timer_event_input_i,
  // Interrupts
  output logic             channel_timer_irq_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   unit_en_reg;
  logic [15:0]            presc_sel_reg;
  logic [15:0]            presc_cnt_reg;
  logic [7:0]             mode_reg;
  logic [CNT_W-1:0]       reload_reg;
  logic [CNT_W-1:0]       counter_reg;
  logic [CNT_W-1:0]       counter_next;
  logic [1:0]             enable_reg;
  logic [1:0]             enable_next;
  chan_state_type         state_reg;
  chan_state_type         state_next;
  logic                   irq_status_reg;
  logic                   irq_mask_reg;
  logic                   chan_irq_reg;
  logic                   irq_reg;
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic [31:0]            rdata_next;
  logic                   err_next;
  logic                   setup;
  logic                   wr_fire;
  logic                   wr_ok;
  logic                   start_lo;
  logic                   start_hi;
  logic                   stop_wr;
  logic                   sw_trig;
  logic                   hw_trig;
  logic                   trigger;
  logic                   eight_bit;
  logic [1:0]             csel_eff;
  logic [3:0]             tick_vec;
  logic                   tick;
  logic [CNT_W-1:0]       reload_eff;
  logic                   done;
  logic                   hold_ok;

  event_if ev ();

  // ----------------------------------------------------------------
  // Input conditioner
  // ----------------------------------------------------------------
  input_conditioner u_cond (
    .clk_i               (clk_i),
    .rstn_i              (rstn_i),
    .clear_i             (~unit_en_reg),
    .timer_event_input_i (timer_event_input_i),
    .ev                  (ev.cond)
  );

  assign ev.filter_en = mode_reg[MODE_FILTER];
  assign ev.edge_sel  = mode_reg[MODE_EDGE_LSB +: 2];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Writes land only in the access cycle, and only the power bit while the unit is off
  always_comb begin
    setup    = psel_i & ~penable_i;
    wr_fire  = psel_i & penable_i & pready_reg & pwrite_i;
    wr_ok    = wr_fire & (unit_en_reg | (paddr_i == OFS_UNIT_CTRL)); // RULE_10
    start_lo = wr_ok & (paddr_i == OFS_START) & pwdata_i[TRIG_LOWER];
    start_hi = wr_ok & (paddr_i == OFS_START) & pwdata_i[TRIG_UPPER] & SPLIT_CAPABLE;
    stop_wr  = wr_ok & (paddr_i == OFS_STOP) & (pwdata_i[TRIG_LOWER] | (pwdata_i[TRIG_UPPER] & SPLIT_CAPABLE));
    hold_ok  = unit_en_reg & ~stop_wr;
  end

  // Read data mux, captured in the setup cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    unique case (paddr_i)
      OFS_UNIT_CTRL:  rdata_next[0]     = unit_en_reg;
      OFS_PRESCALE:   rdata_next[15:0]  = presc_sel_reg;
      OFS_MODE:       rdata_next[7:0]   = mode_reg;
      OFS_RELOAD:     rdata_next[15:0]  = reload_reg;
      OFS_COUNT:      rdata_next[15:0]  = counter_reg; // RULE_09
      OFS_START:      rdata_next        = 32'h0000_0000; // RULE_07
      OFS_STOP:       rdata_next        = 32'h0000_0000;
      OFS_ENABLE:     rdata_next[1:0]   = enable_reg;
      OFS_CH_STATUS:  rdata_next        = 32'h0000_0000; // RULE_09
      OFS_IRQ_STATUS: rdata_next[0]     = irq_status_reg;
      OFS_IRQ_MASK:   rdata_next[0]     = irq_mask_reg;
      default:        err_next          = 1'b1;
    endcase
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & err_next;
      if (setup) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Unit power bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unit_en_reg <= 1'b0;
    end else if (wr_ok && paddr_i == OFS_UNIT_CTRL) begin
      unit_en_reg <= pwdata_i[0];
    end
  end

  // Prescaler, mode and reload registers; cleared while powered down
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_sel_reg <= PRESCALE_RST;
      mode_reg      <= MODE_RST;
      reload_reg    <= RELOAD_RST;
    end else if (!unit_en_reg) begin
      presc_sel_reg <= PRESCALE_RST; // RULE_11
      mode_reg      <= MODE_RST;
      reload_reg    <= RELOAD_RST;
    end else if (wr_ok) begin
      if (paddr_i == OFS_PRESCALE) begin
        presc_sel_reg <= pwdata_i[15:0];
      end
      // Mode is frozen while the channel runs
      if (paddr_i == OFS_MODE && enable_reg == 2'b00) begin
        mode_reg <= pwdata_i[7:0];
      end
      if (paddr_i == OFS_RELOAD) begin
        reload_reg <= pwdata_i[15:0]; // RULE_06
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Free counter, stopped and cleared with the unit clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_cnt_reg <= 16'h0000;
    end else if (!unit_en_reg) begin
      presc_cnt_reg <= 16'h0000; // RULE_10
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 16'h0001;
    end
  end

  // Each output ticks once every 2**select cycles
  always_comb begin
    logic [15:0] msk;
    msk = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      msk         = (16'h0001 << presc_sel_reg[k*PRESC_SEL_W +: PRESC_SEL_W]) - 16'h0001;
      tick_vec[k] = unit_en_reg & ((presc_cnt_reg & msk) == msk);
    end
  end

  // Count clock choice; full choice only in 8-bit split mode
  always_comb begin
    eight_bit  = SPLIT_CAPABLE & mode_reg[MODE_EIGHT_BIT];
    csel_eff   = eight_bit ? mode_reg[MODE_CSEL_LSB +: 2] : {1'b0, mode_reg[MODE_CSEL_LSB]}; // RULE_12
    tick       = tick_vec[csel_eff];
    reload_eff = eight_bit ? {8'h00, reload_reg[7:0]} : reload_reg;
  end

  // ----------------------------------------------------------------
  // Channel control
  // ----------------------------------------------------------------
  // Enable status and triggers
  always_comb begin
    enable_next = enable_reg;
    if (!unit_en_reg) begin
      enable_next = 2'b00;
    end else if (stop_wr) begin
      enable_next[TRIG_LOWER] = enable_reg[TRIG_LOWER] & ~pwdata_i[TRIG_LOWER]; // RULE_08
      enable_next[TRIG_UPPER] = enable_reg[TRIG_UPPER] & ~(pwdata_i[TRIG_UPPER] & SPLIT_CAPABLE);
    end else begin
      enable_next[TRIG_LOWER] = enable_reg[TRIG_LOWER] | start_lo; // RULE_02
      enable_next[TRIG_UPPER] = enable_reg[TRIG_UPPER] | start_hi;
    end
    sw_trig = (start_lo & enable_reg[TRIG_LOWER]) | (start_hi & enable_reg[TRIG_UPPER]); // RULE_05
    hw_trig = ev.edge_pulse & (|enable_reg); // RULE_03
    trigger = (sw_trig | hw_trig) & (state_reg != ST_IDLE);
  end

  // Countdown sequencing; the load waits for the first count clock after a trigger
  always_comb begin
    state_next   = state_reg;
    counter_next = counter_reg;
    done         = 1'b0;
    if (!unit_en_reg) begin
      state_next   = ST_IDLE; // RULE_11
      counter_next = '0;
    end else if (enable_next == 2'b00) begin
      state_next = ST_IDLE; // RULE_08
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_WAIT; // RULE_02
        end
        ST_WAIT: begin
          if (trigger) begin
            state_next = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (tick) begin
            counter_next = reload_eff; // RULE_03
            if (trigger) begin
              state_next = ST_LOAD; // RULE_05
            end else if (reload_eff == '0) begin
              state_next = ST_WAIT;
              done       = 1'b1; // RULE_01
            end else begin
              state_next = ST_COUNT;
            end
          end
        end
        ST_COUNT: begin
          if (trigger) begin
            state_next = ST_LOAD;
          end else if (tick) begin
            counter_next = counter_reg - 16'h0001; // RULE_03
            if (counter_reg == 16'h0001) begin
              state_next = ST_WAIT; // RULE_04
              done       = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Channel state registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg   <= ST_IDLE;
      counter_reg <= '0;
      enable_reg  <= 2'b00;
    end else begin
      state_reg   <= state_next;
      counter_reg <= counter_next;
      enable_reg  <= enable_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status_reg <= 1'b0;
      irq_mask_reg   <= 1'b0;
      chan_irq_reg   <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      chan_irq_reg <= done; // RULE_04
      irq_reg      <= irq_status_reg & irq_mask_reg;
      if (!unit_en_reg) begin
        irq_status_reg <= 1'b0;
        irq_mask_reg   <= 1'b0;
      end else begin
        if (done) begin
          irq_status_reg <= 1'b1;
        end else if (wr_ok && paddr_i == OFS_IRQ_STATUS && pwdata_i[IRQ_DONE]) begin
          irq_status_reg <= 1'b0;
        end
        if (wr_ok && paddr_i == OFS_IRQ_MASK) begin
          irq_mask_reg <= pwdata_i[IRQ_DONE];
        end
      end
    end
  end

  // Outputs
  assign prdata_o            = prdata_reg;
  assign pready_o            = pready_reg;
  assign pslverr_o           = pslverr_reg;
  assign channel_timer_irq_o = chan_irq_reg;
  assign irq_o               = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_start_sets_enable: assert property (start_lo && !stop_wr |=> enable_reg[TRIG_LOWER]) // RULE_02
    else $error("start did not set enable");
  a_sw_retrigger: assert property (sw_trig && hold_ok && state_reg != ST_IDLE |=> state_reg == ST_LOAD) // RULE_05
    else $error("software retrigger not taken");
  a_load_value: assert property (state_reg == ST_LOAD && tick && hold_ok && enable_reg != 2'b00
    |=> counter_reg == $past(reload_eff)) // RULE_03
    else $error("counter not loaded from reload");
  a_count_step: assert property (state_reg == ST_COUNT && tick && !trigger && hold_ok
    |=> counter_reg == $past(counter_reg) - 16'h0001) // RULE_03
    else $error("counter did not step down");
  a_zero_irq: assert property (done |=> chan_irq_reg && counter_reg == '0 && state_reg == ST_WAIT) // RULE_04
    else $error("zero reached without interrupt and halt");
  a_halted_wait: assert property (state_reg == ST_WAIT && !trigger && hold_ok |=> $stable(counter_reg)) // RULE_04
    else $error("counter moved while halted");
  a_reload_deferred: assert property (state_reg == ST_COUNT && !tick && !trigger && hold_ok
    |=> $stable(counter_reg)) // RULE_06
    else $error("reload write disturbed the countdown");
  a_stop_holds: assert property (stop_wr && pwdata_i[TRIG_LOWER] && !enable_reg[TRIG_UPPER]
    |=> state_reg == ST_IDLE && !enable_reg[TRIG_LOWER] && $stable(counter_reg)) // RULE_08
    else $error("stop did not halt and hold");
  a_start_reads_zero: assert property (setup && paddr_i == OFS_START |=> prdata_reg == 32'h0000_0000) // RULE_07
    else $error("start register read nonzero");
  a_count_readback: assert property (setup && !pwrite_i && paddr_i == OFS_COUNT
    |=> prdata_reg[15:0] == $past(counter_reg)) // RULE_09
    else $error("count readback mismatch");
  a_off_ignores: assert property (wr_fire && !unit_en_reg && paddr_i == OFS_RELOAD
    |=> reload_reg == RELOAD_RST) // RULE_10
    else $error("write accepted while unit off");
  a_off_clears: assert property (!unit_en_reg |=> enable_reg == 2'b00 && counter_reg == '0
    && state_reg == ST_IDLE && !irq_status_reg) // RULE_11
    else $error("power off did not clear state");
  a_clock_choice: assert property (!eight_bit |-> !csel_eff[1]) // RULE_12
    else $error("upper prescaled clocks chosen outside 8-bit mode");

  c_countdown_done: cover property (state_reg == ST_COUNT ##1 done);
  c_edge_trigger:   cover property (hw_trig && state_reg == ST_WAIT);
  c_sw_trigger:     cover property (sw_trig);
  c_stop_running:   cover property (stop_wr && state_reg == ST_COUNT);

endmodule

// ==== verif/event_source.sv ====
// Behavioural external event source driving the timer event pin
`timescale 1ns/1ns
module event_source (
  // Clock and request
  input  wire logic clk_i,
  input  wire logic fire_i,
  // Pin
  output logic      pin_o
);
  int hold_cnt = 0;
  // Rising edge held eight clocks so the filter always accepts it
  always @(posedge clk_i) begin
    if (fire_i) hold_cnt <= 8;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end
  assign pin_o = (hold_cnt > 0);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the delay-counter timer channel
`timescale 1ns/1ns
module tb_top;
  import timer_pkg::*;
  logic        clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, c1;
  logic        pready, pslverr, pin, tirq, irq, err;
  int          error_cnt = 0, tests_run = 0, cyc = 0, d1, d2, d3, r1, r2;

  timer_delay_counter dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .timer_event_input_i(pin), .channel_timer_irq_o(tirq), .irq_o(irq));
  event_source src_u (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  // Cycle stamp of the next interrupt pulse, -1 if none within lim
  task automatic wait_irq(input int lim, output int d);
    d = -1;
    for (int i = 0; i < lim && d < 0; i++) begin
      @(posedge clk_i);
      if (tirq === 1'b1) d = cyc;
    end
  endtask
  // Software trigger, optional reload rewrite mid count, returns delay
  task automatic trig(input logic mid, input int nv, output int d);
    int t0;
    apb(1'b1, OFS_START, 32'h0000_0001);
    t0 = cyc;
    if (mid) apb(1'b1, OFS_RELOAD, nv);
    wait_irq(300, d);
    d = d - t0;
  endtask
  task automatic pulse_pin();
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic stop_test();
    $display("error_cnt %0d tests_run %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, cycle stamp and watchdog
  // ----------------------------------------------------------------
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  initial begin
    #3_000_000;
    error_cnt++;
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hd20b));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b1, OFS_RELOAD, 32'h0000_0005);
    apb(1'b1, OFS_UNIT_CTRL, 32'h0000_0001);
    rchk("reload", OFS_RELOAD, 32'h0000_0000);
    rchk("enable", OFS_ENABLE, 32'h0000_0000);
    rchk("ch status", OFS_CH_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("slverr", err, 32'h0000_0001);
    $display("test reset done");
    // Pin trigger, halt at zero, mask and clear of the interrupt
    apb(1'b1, OFS_PRESCALE, $urandom & 32'h0000_FFF0);
    apb(1'b1, OFS_MODE, 32'h0000_0008);
    apb(1'b1, OFS_RELOAD, 32'h0000_0004);
    apb(1'b1, OFS_START, 32'h0000_0001);
    rchk("enable", OFS_ENABLE, 32'h0000_0001);
    rchk("start", OFS_START, 32'h0000_0000);
    pulse_pin();
    wait_irq(100, d1);
    chk("pin irq", d1 > 0, 32'h0000_0001);
    wait_irq(30, d2);
    chk("halted", d2, -1);
    rchk("count zero", OFS_COUNT, 32'h0000_0000);
    rchk("irq status", OFS_IRQ_STATUS, 32'h0000_0001);
    chk("masked", irq, 32'h0000_0000);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq out", irq, 32'h0000_0001);
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq clear", irq, 32'h0000_0000);
    $display("test pin done");
    // Period follows reload, new reload waits for the next load
    r1 = 10 + $urandom_range(20, 0);
    r2 = r1 + 1 + $urandom_range(9, 0);
    apb(1'b1, OFS_RELOAD, r1);
    trig(1'b0, 0, d1);
    chk("period abs", d1, r1 + 1);
    trig(1'b1, r2, d2);
    chk("old reload", d2, d1);
    trig(1'b0, 0, d3);
    chk("period", d3 - d1, r2 - r1);
    $display("test period done");
    // Stop holds the count and ignores the pin
    apb(1'b1, OFS_START, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
    apb(1'b1, OFS_STOP, 32'h0000_0001);
    rchk("enable", OFS_ENABLE, 32'h0000_0000);
    apb(1'b0, OFS_COUNT, 32'h0000_0000);
    c1 = rd;
    chk("count live", c1 != 0, 32'h0000_0001);
    rchk("count hold", OFS_COUNT, c1);
    pulse_pin();
    wait_irq(60, d1);
    chk("stopped", d1, -1);
    $display("test stop done");
    // Upper half enable and filtered input
    apb(1'b1, OFS_START, 32'h0000_0002);
    rchk("upper enable", OFS_ENABLE, 32'h0000_0002);
    apb(1'b1, OFS_STOP, 32'h0000_0002);
    apb(1'b1, OFS_MODE, 32'h0000_0028);
    rchk("mode", OFS_MODE, 32'h0000_0028);
    apb(1'b1, OFS_START, 32'h0000_0001);
    pulse_pin();
    wait_irq(100, d1);
    chk("filtered irq", d1 > 0, 32'h0000_0001);
    $display("test filter done");
    // Power off returns registers to reset values
    apb(1'b1, OFS_UNIT_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_UNIT_CTRL, 32'h0000_0001);
    rchk("reload off", OFS_RELOAD, 32'h0000_0000);
    rchk("mode off", OFS_MODE, 32'h0000_0000);
    rchk("enable off", OFS_ENABLE, 32'h0000_0000);
    $display("test power done");
    stop_test();
  end
endmodule
